// File: ext_bus_pkg.sv
// Purpose: shared types and constants for the external memory pin block
// Assumes: 125 MHz ref_clk, 8 ns period
// Notes:   pin lane numbering follows the strobe convention (lane 0 = MSB)
package ext_bus_pkg;
	localparam int CLK_PERIOD_PS   = 8000;    // ref_clk period
	localparam int ACCESS_TIME_NS  = 40;      // least strobe time, short
	localparam int FIRST_TIME_NS   = 80;      // least first access, long
	localparam logic [3:0] SHORT_CYCLES =
		4'((ACCESS_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [3:0] LONG_CYCLES =
		4'((FIRST_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [1:0] BCLK_HALF = 2'h2;  // burst clock half period
	localparam logic [1:0] BOOT_SYNC_WAIT = 2'h3; // edges to fill sync
	// sdram pin fields on the general address bus
	localparam int BANK_LO  = 16;             // non-interleaved bank A[20:16]
	localparam int IBANK_LO = 21;             // interleaved bank A[24:21]
	localparam int RC_LO    = 1;              // row/col 9..0 on A[10:1]
	localparam int BOOT_MSB = 3;              // must read low

	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_SETUP  = 3'h1,
		ST_ACCESS = 3'h2,
		ST_BURST  = 3'h3,
		ST_FINISH = 3'h4
	} busState_type;

	typedef struct packed {
		logic        write;      // 1 write, 0 read
		logic        burst;      // burst read from synchronous flash
		logic        sdram;      // cycle goes to an sdram select
		logic        interleave; // sdram interleaved bank addressing
		logic [2:0]  sel;        // chip select 0..5 or sdram select 0..1
		logic [3:0]  byteEn;     // bit i enables D[8i+7:8i]
		logic [25:0] addr;       // byte address for async/burst
		logic [11:0] rowCol;     // sdram row/column lines
		logic [4:0]  bank;       // sdram bank lines
		logic [31:0] wdata;      // write data
		logic [3:0]  beats;      // burst beats minus one
	} memReq_type;
endpackage

// File: ext_mem_model.sv
// Purpose: far-side memory model for the external pin block
// Assumes: pins sampled on the rising edge of ref_clk
// Notes:   released data bus flips every cycle so stale data shows
`timescale 1ns/1ps
module ext_mem_model (
	input  wire logic        ref_clk,         // system clock
	input  wire logic        nrst,            // async reset
	input  wire logic        outEnN,          // read enable from block
	input  wire logic [25:0] addrOut,         // address pins
	input  wire logic        ackEn,           // bench: answer with ack
	input  wire logic        restartReq,      // bench: abort the burst
	output logic [31:0]      dataIn,          // data pins to block
	output logic             extDataAckN,     // ack pin, pulled up
	output logic             burstRestartInN  // restart pin, pulled up
);
	// drive the bus only while output enable is low
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			dataIn <= 32'h00000000;
		end else if (!outEnN) begin
			dataIn <= 32'h5A000000 ^ {6'h00, addrOut};
		end else begin
			dataIn <= ~dataIn; // released: the stale word returns every other cycle
		end
	end
	// prompt ack, one cycle after the read opens
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			extDataAckN <= 1'b1;
		end else begin
			extDataAckN <= !(ackEn && !outEnN);
		end
	end
	// restart only when the bench commands it
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			burstRestartInN <= 1'b1;
		end else begin
			burstRestartInN <= !restartReq;
		end
	end
endmodule

// File: external_memory_bus_pins.sv
// Purpose: drives external memory pins: strobes, selects, burst, sdram mux
// Assumes: one clock; requests come from logic on ref_clk
// Notes:   pin inputs pass two flops; burst applies to reads only
`timescale 1ns/1ps

// Functional notes
// - four low strobes, strobe 0 is MSB lane
// - output enable low lets memory drive reads
// - direction high read, low write
// - six selects; pins 3:2 default sdram selects
// - select 4 pin doubles as data acknowledge
// - restart input aborts burst, long first access
// - latch strobe captures burst start address
// - burst clock runs during burst accesses
// - boot pins caught at reset, MSB low
// - non-interleaved bank on A[20:16]
// - interleaved bank on A[24:21]
// - row/col 9..0 on A[10:1]
module external_memory_bus_pins (
	input  wire logic                    ref_clk,         // system clock
	input  wire logic                    nrst,            // async reset
	input  wire logic                    reqValid,        // request offered
	input  wire ext_bus_pkg::memReq_type reqData,         // request content
	output logic                         reqReady,        // block idle
	output logic                         respValid,       // read word ready
	output logic [31:0]                  respData,        // read word
	input  wire logic                    csMux23,         // 1: pins 3:2 are cs
	input  wire logic                    ackMode,         // 1: pin 4 is ack
	output logic [25:0]                  addrOut,         // address pins
	output logic [1:0]                   rowColHi,        // row/col lines 11:10
	output logic [31:0]                  dataOut,         // data pins out
	output logic                         dataOe,          // data drive enable
	input  wire logic [31:0]             dataIn,          // data pins in
	output logic [3:0]                   byteLaneStrobeN, // byte strobes
	output logic                         outEnN,          // output enable
	output logic                         rwDir,           // read high
	output logic [5:0]                   chipSelN,        // select pins
	output logic                         chipSel4Oe,      // pin 4 driven
	input  wire logic                    extDataAckN,     // pin 4 as input
	input  wire logic                    burstRestartInN, // restart from flash
	output logic                         burstAddrLatchN, // address latch
	output logic                         burstClk,        // burst clock
	input  wire logic [3:0]              bootPins,        // boot straps
	output logic [3:0]                   bootMode,        // captured mode
	output logic                         bootValid,       // mode captured
	output logic                         bootPinErr       // msb strap high
);
	import ext_bus_pkg::*;

	busState_type state_q, state_d;   // access sequencer
	memReq_type   req_q;              // request held for the access
	logic [3:0]   waitCnt_q;          // strobe cycles left
	logic [3:0]   beatCnt_q;          // burst beats left
	logic [1:0]   halfCnt_q;          // burst clock phase counter
	logic [1:0]   bootCnt_q;          // settle count after reset
	logic         muxSel_q, ackSel_q; // pin function choices
	logic [31:0]  dIn1_q, dIn2_q;     // data pin synchroniser
	logic [1:0]   ack_q, rst_q;       // ack and restart synchronisers
	logic [3:0]   boot1_q, boot2_q;   // boot strap synchroniser
	logic         ackHit, restartHit, waitDone, beatEdge;

	assign ackHit     = ackSel_q && !ack_q[1];
	assign restartHit = !rst_q[1];
	assign waitDone   = (waitCnt_q == 4'h0) || ackHit;
	assign beatEdge   = burstClk && (halfCnt_q == 2'h0);

	// lane order is reversed on the pins: strobe 0 serves D[31:24]
	function automatic logic [3:0] laneStrobes(input logic [3:0] be);
		laneStrobes = ~{be[0], be[1], be[2], be[3]};
	endfunction

	// all pin inputs pass two flops before any logic looks at them
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			dIn1_q  <= 32'h0000_0000;
			dIn2_q  <= 32'h0000_0000;
			ack_q   <= 2'h3;
			rst_q   <= 2'h3;
			boot1_q <= 4'h0;
			boot2_q <= 4'h0;
		end else begin
			dIn1_q  <= dataIn;
			dIn2_q  <= dIn1_q;
			ack_q   <= {ack_q[0], extDataAckN};
			rst_q   <= {rst_q[0], burstRestartInN};
			boot1_q <= bootPins;
			boot2_q <= boot1_q;
		end
	end

	// function choices reset to sdram selects and cs4 as output
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			muxSel_q <= 1'b0;
			ackSel_q <= 1'b0;
		end else if (state_q == ST_IDLE) begin
			// only change pin roles between accesses to avoid glitches
			muxSel_q <= csMux23;
			ackSel_q <= ackMode;
		end
	end

	// boot straps caught once, after the synchroniser has filled
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			bootCnt_q  <= 2'h0;
			bootValid  <= 1'b0;
			bootMode   <= 4'h0;
			bootPinErr <= 1'b0;
		end else if (!bootValid) begin
			if (bootCnt_q == BOOT_SYNC_WAIT) begin
				bootValid  <= 1'b1;
				bootMode   <= boot2_q;
				bootPinErr <= boot2_q[BOOT_MSB];
			end else begin
				bootCnt_q <= bootCnt_q + 2'h1;
			end
		end
	end

	// next state of the access sequencer
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: begin
				// reqReady stays low for one edge after reset release
				if (reqValid && reqReady) begin
					state_d = ST_SETUP;
				end
			end
			ST_SETUP: begin
				state_d = ST_ACCESS;
			end
			ST_ACCESS: begin
				if (waitDone) begin
					state_d = (req_q.burst && !req_q.write) ? ST_BURST
						: ST_FINISH;
				end
			end
			ST_BURST: begin
				if (restartHit) begin
					state_d = ST_SETUP;
				end else if (beatEdge && beatCnt_q == 4'h0) begin
					state_d = ST_FINISH;
				end
			end
			ST_FINISH: begin
				state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// sequencer, request hold and counters
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			state_q   <= ST_IDLE;
			req_q     <= '0;
			waitCnt_q <= 4'h0;
			beatCnt_q <= 4'h0;
		end else begin
			state_q <= state_d;
			if (state_q == ST_IDLE && reqValid && reqReady) begin
				req_q     <= reqData;
				beatCnt_q <= reqData.beats;
				// a burst read opens with the long first access
				waitCnt_q <= (reqData.burst && !reqData.write) ?
					LONG_CYCLES : SHORT_CYCLES;
			end else if (state_q == ST_BURST && restartHit) begin
				waitCnt_q <= LONG_CYCLES;
				beatCnt_q <= req_q.beats;
			end else if (state_q == ST_ACCESS && waitCnt_q != 4'h0) begin
				waitCnt_q <= waitCnt_q - 4'h1;
			end else if (state_q == ST_BURST && beatEdge) begin
				beatCnt_q <= beatCnt_q - 4'h1;
			end
		end
	end

	// burst clock: toggles every BCLK_HALF cycles, low outside bursts
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			halfCnt_q <= 2'h0;
			burstClk  <= 1'b0;
		end else if (state_d == ST_BURST) begin
			halfCnt_q <= (halfCnt_q == 2'h0) ? BCLK_HALF - 2'h1
				: halfCnt_q - 2'h1;
			if (halfCnt_q == 2'h0) begin
				burstClk <= ~burstClk;
			end
		end else begin
			halfCnt_q <= 2'h0;
			burstClk  <= 1'b0;
		end
	end

	// read answer: data is the synchronised pin value, three cycles late
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			respValid <= 1'b0;
			respData  <= 32'h0000_0000;
			reqReady  <= 1'b0;
		end else begin
			reqReady  <= (state_d == ST_IDLE);
			respValid <= !req_q.write && ((state_q == ST_ACCESS &&
				waitDone && !req_q.burst) ||
				(state_q == ST_BURST && beatEdge && !restartHit));
			respData  <= dIn2_q;
		end
	end

	// pin drive follows the next state, so pins line up with state_q
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			addrOut         <= 26'h000_0000;
			rowColHi        <= 2'h0;
			dataOut         <= 32'h0000_0000;
			dataOe          <= 1'b0;
			byteLaneStrobeN <= 4'hF;
			outEnN          <= 1'b1;
			rwDir           <= 1'b1;
			chipSelN        <= 6'h3F;
			chipSel4Oe      <= 1'b1;
			burstAddrLatchN <= 1'b1;
		end else begin
			chipSel4Oe      <= !ackSel_q;
			// a burst flagged write runs as a plain write: no latch
			burstAddrLatchN <= !(state_d == ST_SETUP &&
				(state_q == ST_IDLE ? reqData.burst && !reqData.write
				: req_q.burst));
			if (state_d == ST_SETUP && state_q == ST_IDLE) begin
				addrOut  <= reqData.addr;
				rowColHi <= reqData.rowCol[11:10];
				if (reqData.sdram) begin
					addrOut[RC_LO +: 10] <= reqData.rowCol[9:0];
					if (reqData.interleave) begin
						addrOut[IBANK_LO +: 4] <= reqData.bank[3:0];
					end else begin
						addrOut[BANK_LO +: 5] <= reqData.bank;
					end
				end
				rwDir   <= !reqData.write;
				dataOut <= reqData.wdata;
			end
			if (state_d == ST_SETUP || state_d == ST_ACCESS ||
				state_d == ST_BURST) begin
				dataOe <= req_q.write || (state_q == ST_IDLE &&
					reqData.write);
			end else begin
				dataOe <= 1'b0;
			end
			if (state_d == ST_ACCESS || state_d == ST_BURST) begin
				byteLaneStrobeN <= laneStrobes(req_q.byteEn);
				outEnN          <= req_q.write;
				chipSelN        <= 6'h3F;
				if (req_q.sdram) begin
					if (!muxSel_q) begin
						chipSelN[2 + req_q.sel[0]] <= 1'b0;
					end
				end else if (!(req_q.sel[1:0] == 2'h0 &&
					req_q.sel[2] && ackSel_q) &&
					!(req_q.sel[2:1] == 2'h1 && !muxSel_q)) begin
					chipSelN[req_q.sel] <= 1'b0;
				end
			end else begin
				byteLaneStrobeN <= 4'hF;
				outEnN          <= 1'b1;
				chipSelN        <= 6'h3F;
			end
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);

	property p_idleNegated;
		state_q == ST_IDLE |-> byteLaneStrobeN == 4'hF && outEnN &&
			chipSelN == 6'h3F;
	endproperty
	a_idleNegated: assert property (p_idleNegated)
		else $error("strobes active while idle");

	property p_laneOrder;
		state_q == ST_ACCESS |-> byteLaneStrobeN[0] == !req_q.byteEn[3] &&
			byteLaneStrobeN[3] == !req_q.byteEn[0];
	endproperty
	a_laneOrder: assert property (p_laneOrder)
		else $error("byte strobe lane order wrong");

	property p_oeOnlyRead;
		!outEnN |-> rwDir && !dataOe;
	endproperty
	a_oeOnlyRead: assert property (p_oeOnlyRead)
		else $error("output enable during write");

	property p_writeDir;
		state_q == ST_ACCESS && req_q.write |-> !rwDir && outEnN;
	endproperty
	a_writeDir: assert property (p_writeDir)
		else $error("direction not low in write");

	property p_sdramPins;
		!muxSel_q && state_q == ST_ACCESS && !req_q.sdram |->
			chipSelN[3:2] == 2'h3;
	endproperty
	a_sdramPins: assert property (p_sdramPins)
		else $error("cs 3:2 used while sdram owns pins");

	property p_ackPin;
		ackSel_q && $past(ackSel_q) |-> !chipSel4Oe && chipSelN[4];
	endproperty
	a_ackPin: assert property (p_ackPin)
		else $error("pin 4 driven in ack mode");

	property p_restart;
		state_q == ST_BURST && restartHit |=> state_q == ST_SETUP &&
			!burstAddrLatchN ##1 state_q == ST_ACCESS &&
			waitCnt_q == LONG_CYCLES;
	endproperty
	a_restart: assert property (p_restart)
		else $error("restart did not reopen long burst");

	property p_latch;
		!burstAddrLatchN |-> state_q == ST_SETUP && req_q.burst &&
			!req_q.write;
	endproperty
	a_latch: assert property (p_latch)
		else $error("address latch outside burst setup");

	property p_bclk;
		$changed(burstClk) |-> state_q == ST_BURST ||
			$past(state_q) == ST_BURST;
	endproperty
	a_bclk: assert property (p_bclk)
		else $error("burst clock moved outside burst");

	property p_bootHold;
		$past(bootValid) |-> $stable(bootMode) && bootValid;
	endproperty
	a_bootHold: assert property (p_bootHold)
		else $error("boot mode changed after capture");

	property p_bank;
		state_q == ST_SETUP && $past(state_q) == ST_IDLE && req_q.sdram |->
			addrOut[RC_LO +: 10] == req_q.rowCol[9:0] &&
			(req_q.interleave ? addrOut[IBANK_LO +: 4] == req_q.bank[3:0]
			: addrOut[BANK_LO +: 5] == req_q.bank);
	endproperty
	a_bank: assert property (p_bank)
		else $error("sdram address mux wrong");

	c_read:    cover property (state_q == ST_ACCESS && !req_q.write
		##[1:20] respValid);
	c_burst:   cover property (state_q == ST_BURST ##[1:80]
		state_q == ST_FINISH);
	c_restart: cover property (state_q == ST_BURST && restartHit);
	c_ackEnd:  cover property (state_q == ST_ACCESS && ackHit);
endmodule

// File: external_memory_bus_pins_bench.sv
// Purpose: self-checking bench for the external memory pin block
// Assumes: 125 MHz ref_clk, inputs driven on the falling edge
// Notes:   capture keeps the pin values seen while strobes are low
`timescale 1ns/1ps
module external_memory_bus_pins_bench;
	import ext_bus_pkg::*;
	logic        ref_clk = 0, nrst = 0, reqValid = 0; // clock, reset, req
	logic        csMux23 = 0, ackMode = 0;            // pin roles
	logic        ackEn = 0, restartReq = 0;           // model controls
	logic [3:0]  bootPins = 4'h5;                     // straps, msb low
	memReq_type  reqData = '0;                        // request content
	logic        reqReady, respValid, outEnN, rwDir;  // block outputs
	logic        chipSel4Oe, burstAddrLatchN, burstClk, dataOe;
	logic        bootValid, bootPinErr, extDataAckN, burstRestartInN;
	logic [31:0] respData, dataOut, dataIn;           // data paths
	logic [25:0] addrOut;                             // address pins
	logic [1:0]  rowColHi;                            // row/col 11:10
	logic [3:0]  byteLaneStrobeN, bootMode;           // strobes, mode
	logic [5:0]  chipSelN;                            // select pins
	int          fails = 0, checked = 0;              // tallies
	int          words, latches, rises, lat;          // capture counts
	logic [3:0]  strb;                                // strobes seen
	logic [5:0]  cs;                                  // selects seen
	logic        oe, dir, cs4oe, pb;                  // levels seen
	logic [25:0] ad;                                  // address seen
	logic [1:0]  hi;                                  // row/col hi seen
	logic [31:0] rd, dOut;                            // data seen

	external_memory_bus_pins dut_u (.ref_clk(ref_clk), .nrst(nrst),
		.reqValid(reqValid), .reqData(reqData), .reqReady(reqReady),
		.respValid(respValid), .respData(respData), .csMux23(csMux23),
		.ackMode(ackMode), .addrOut(addrOut), .rowColHi(rowColHi),
		.dataOut(dataOut), .dataOe(dataOe), .dataIn(dataIn),
		.byteLaneStrobeN(byteLaneStrobeN), .outEnN(outEnN),
		.rwDir(rwDir), .chipSelN(chipSelN), .chipSel4Oe(chipSel4Oe),
		.extDataAckN(extDataAckN), .burstRestartInN(burstRestartInN),
		.burstAddrLatchN(burstAddrLatchN), .burstClk(burstClk),
		.bootPins(bootPins), .bootMode(bootMode), .bootValid(bootValid),
		.bootPinErr(bootPinErr));

	ext_mem_model mem_u (.ref_clk(ref_clk), .nrst(nrst), .outEnN(outEnN),
		.addrOut(addrOut), .ackEn(ackEn), .restartReq(restartReq),
		.dataIn(dataIn), .extDataAckN(extDataAckN),
		.burstRestartInN(burstRestartInN));

	// free-running system clock, 8 ns period
	always #4 ref_clk = ~ref_clk;

	// one comparison, reported at once on mismatch
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		checked++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// request builder; flags are write, burst, sdram, interleave
	function automatic memReq_type mk(logic [3:0] fl, logic [2:0] s,
		logic [3:0] be);
		memReq_type r;
		r = '0;
		{r.write, r.burst, r.sdram, r.interleave} = fl;
		r.sel = s;
		r.byteEn = be;
		r.addr = 26'h0000104;
		r.rowCol = 12'hABC;
		r.bank = 5'h15;
		r.wdata = 32'hC3A51E0F;
		r.beats = 4'h3;
		return r;
	endfunction

	// offer one request, hold until taken, then watch until idle again
	task automatic run(input memReq_type r, input logic rst);
		int n;
		words = 0;
		latches = 0;
		rises = 0;
		lat = 0;
		pb = 1'b0;
		@(negedge ref_clk);
		reqValid = 1'b1;
		reqData = r;
		do @(posedge ref_clk); while (reqReady !== 1'b1);
		@(negedge ref_clk);
		reqValid = 1'b0;
		for (n = 1; n < 200; n++) begin
			if (n > 1) @(negedge ref_clk);
			if (byteLaneStrobeN !== 4'hF) begin
				strb = byteLaneStrobeN;
				cs = chipSelN;
				oe = outEnN;
				dir = rwDir;
				ad = addrOut;
				hi = rowColHi;
				cs4oe = chipSel4Oe;
			end
			if (dataOe === 1'b1) dOut = dataOut;
			if (burstAddrLatchN === 1'b0) latches++;
			if (burstClk === 1'b1 && !pb) rises++;
			pb = burstClk;
			restartReq = rst && respValid === 1'b1 && words == 0;
			if (respValid === 1'b1) begin
				if (words == 0) lat = n;
				words++;
				rd = respData;
			end
			if (reqReady === 1'b1) break;
		end
		restartReq = 1'b0;
		chk("idle strobes", 4'hF, byteLaneStrobeN);
		chk("idle selects", 6'h3F, chipSelN);
		chk("idle output enable", 1, outEnN);
		chk("idle burst clock", 0, burstClk);
	endtask

	// boot capture and idle pins after each reset
	task automatic t_boot(input logic [3:0] exp);
		repeat (6) @(negedge ref_clk);
		chk("boot valid", 1, bootValid);
		chk("boot mode", exp, bootMode);
		chk("boot msb flag", exp[3], bootPinErr);
		chk("reset strobes", 4'hF, byteLaneStrobeN);
	endtask

	// single read: lane order, select, enable, direction, timing
	task automatic t_read;
		run(mk(4'h0, 3'h1, 4'h1), 1'b0);
		chk("read strobes", 4'h7, strb);
		chk("read select", 6'h3D, cs);
		chk("read enable", 0, oe);
		chk("read direction", 1, dir);
		chk("read data", 32'h5A000104, rd);
		chk("read latency", 1, lat >= 7 && lat <= 8);
	endtask

	// write: lane 0 strobe for the top byte, direction low, no enable
	task automatic t_write;
		run(mk(4'h8, 3'h0, 4'h8), 1'b0);
		chk("write strobes", 4'hE, strb);
		chk("write select", 6'h3E, cs);
		chk("write direction", 0, dir);
		chk("write enable", 1, oe);
		chk("write data", 32'hC3A51E0F, dOut);
		chk("write words", 0, words);
	endtask

	// sdram address sharing and select pin roles
	task automatic t_sdram;
		run(mk(4'h2, 3'h1, 4'hF), 1'b0);
		chk("sdram select", 6'h37, cs);
		chk("bank lines", 5'h15, ad[20:16]);
		chk("row col low", 10'h2BC, ad[10:1]);
		chk("row col high", 2'h2, hi);
		run(mk(4'h3, 3'h0, 4'hF), 1'b0);
		chk("interleave bank", 4'h5, ad[24:21]);
		chk("sdram select 0", 6'h3B, cs);
		run(mk(4'h0, 3'h2, 4'hF), 1'b0);
		chk("cs2 held by sdram", 6'h3F, cs);
		csMux23 = 1'b1;
		run(mk(4'h0, 3'h2, 4'hF), 1'b0);
		chk("cs2 as select", 6'h3B, cs);
		csMux23 = 1'b0;
	endtask

	// pin 4 as acknowledge ends the read early
	task automatic t_ack;
		ackMode = 1'b1;
		ackEn = 1'b1;
		run(mk(4'h0, 3'h4, 4'hF), 1'b0);
		chk("pin 4 released", 0, cs4oe);
		chk("no select on pin 4", 6'h3F, cs);
		chk("ack ends early", 1, lat > 0 && lat < 7);
		ackMode = 1'b0;
		ackEn = 1'b0;
	endtask

	// burst read, then a burst restarted after its first word
	task automatic t_burst;
		run(mk(4'h4, 3'h0, 4'hF), 1'b0);
		chk("burst words", 4, words);
		chk("burst latch", 1, latches);
		chk("burst clock edges", 1, rises >= 4);
		chk("long first access", 1, lat >= 10);
		run(mk(4'h4, 3'h0, 4'hF), 1'b1);
		chk("restart relatch", 2, latches);
		chk("restart words", 1, words >= 4);
	endtask

	// verdict, reached from the main sequence or the watchdog
	task automatic close_out;
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// main sequence; straps change only while reset is held
	initial begin
		repeat (4) @(posedge ref_clk);
		@(negedge ref_clk);
		nrst = 1'b1;
		t_boot(4'h5);
		t_read;
		t_write;
		t_sdram;
		t_ack;
		t_burst;
		nrst = 1'b0;
		bootPins = 4'hD;
		repeat (4) @(negedge ref_clk);
		nrst = 1'b1;
		t_boot(4'hD);
		close_out;
	end

	// tests need under three hundred cycles; far beyond that is a hang
	initial begin
		#100us;
		fails++;
		close_out;
	end
endmodule
